// [bench/plt_core_properties.sv]
module plt_core_properties (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // stimulus side
    input wire logic i_ref_half_tick,
    input wire plt_pkg::plt_reg_req_t i_reg,
    // design outputs
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_led_drive,
    input wire logic o_rx_sample,
    input wire logic o_filt_power_down,
    input wire logic o_unfilt_power_down
);
    timeunit 1ns;
    timeprecision 100ps;
    import plt_pkg::*;

    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_rd(a);
        i_reg.rd && i_reg.addr == a;
    endsequence
    sequence s_wr_en;
        i_reg.wr && i_reg.addr == ADDR_LIGHT_ENABLE;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_rd_answer: assert property (
        i_reg.rd |=> o_reg_rvalid) else $error("read got no answer");
    a_rvalid_cause: assert property (
        o_reg_rvalid |-> $past(i_reg.rd)) else $error("stray rvalid");
    a_rdata_hold: assert property (
        !i_reg.rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
    a_prox_width: assert property (
        s_rd(ADDR_PROX_MSB) |=> o_reg_rdata[7:4] == 4'h0)
        else $error("prox msb wider than 12 bits");
    a_led_on_tick: assert property (
        !i_ref_half_tick |=> $stable(o_led_drive))
        else $error("led moved without tick");
    a_sample_cause: assert property (
        o_rx_sample |-> $past(i_ref_half_tick))
        else $error("sample without tick");
    a_sample_single: assert property (
        o_rx_sample |=> !o_rx_sample) else $error("sample too long");
    a_enable_decode: assert property (
        s_wr_en |=> o_filt_power_down == !$past(i_reg.wdata[0])
        && o_unfilt_power_down == !$past(i_reg.wdata[1]))
        else $error("power down not from enable");
    a_pd_hold: assert property (
        !(i_reg.wr && i_reg.addr == ADDR_LIGHT_ENABLE) |=>
        $stable(o_filt_power_down) && $stable(o_unfilt_power_down))
        else $error("power down moved");
endmodule

bind plt_core plt_core_properties u_props (.i_mclk, .i_reset_n,
    .i_ref_half_tick, .i_reg, .o_reg_rdata, .o_reg_rvalid, .o_led_drive,
    .o_rx_sample, .o_filt_power_down, .o_unfilt_power_down);

// [bench/plt_ref_osc.sv]
module plt_ref_osc (
    // clock
    input wire logic i_mclk,
    // reference half-period strobe
    output logic o_half_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    int acc = 0;
    initial o_half_tick = 1'b0;
    // 8 MHz half ticks
    // accumulator keeps the long-run rate exact, spacing 3 or 4
    always @(posedge i_mclk) begin
        #2;
        o_half_tick = (acc + 8 >= 25);
        acc = (acc + 8) % 25;
    end
endmodule

// [bench/tb.sv]
`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("BAD %0t got %h exp %h", $time, g, e); \
    end \
end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import plt_pkg::*;
    logic i_mclk, i_reset_n, tick, led, smp, rv, pdf, pdu;
    logic [7:0] rdata, d, c;
    logic [15:0] v, w;
    plt_reg_req_t req;
    plt_conv_t cv [3];
    logic [15:0] res [3];
    logic [7:0] d_tab [6] = '{8'h14, 8'h14, 8'h08, 8'h04, 8'h00, 8'h10};
    // host keeps every lag code at or below its divider value
    logic [7:0] c_tab [6] = '{8'h07, 8'h03, 8'h05, 8'h03, 8'h00, 8'h00};
    int err_count, checks;

    plt_ref_osc osc (.i_mclk(i_mclk), .o_half_tick(tick));
    plt_core dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_ref_half_tick(tick), .i_reg(req), .o_reg_rdata(rdata),
        .o_reg_rvalid(rv), .i_prox_conv(cv[0]), .i_filt_conv(cv[1]),
        .i_unfilt_conv(cv[2]), .o_led_drive(led), .o_rx_sample(smp),
        .o_filt_power_down(pdf), .o_unfilt_power_down(pdu));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task results;
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge i_mclk);
        #2 req = {2'b10, a, dt};
        @(posedge i_mclk);
        #2 req = {2'b00, ~a, ~dt};
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        #2 req = {2'b01, a, 8'h00};
        @(posedge i_mclk);
        #2 req = {2'b00, ~a, 8'hff};
        `CHK(rv, 1'b1)
        `CHK(rdata, e)
    endtask

    task cnv(input int ch, input logic [15:0] x);
        @(posedge i_mclk);
        #2 cv[ch] = {1'b1, x};
        @(posedge i_mclk);
        #2 cv[ch] = {1'b0, ~x};
    endtask

    function int lag_of(input logic [7:0] code);
        return (code < 2) ? 0 : code - 1;
    endfunction

    // counts ticks over one clean led period after the settings land
    task meas(input logic [7:0] dv, input logic [7:0] cd);
        int n, hi, sp, ns, per, ph, k, dd;
        logic pl;
        wr(ADDR_LED_PULSE_DIVIDER, dv);
        wr(ADDR_RECEIVER_SAMPLE_LAG, cd);
        dd = (dv == 0) ? 1 : dv;
        n = 0;
        hi = -1;
        sp = -1;
        ns = 0;
        per = -1;
        ph = 0;
        pl = led;
        for (k = 0; k < 3000 && ph < 3; k++) begin
            @(posedge i_mclk);
            #1;
            if (tick)
                n++;
            if (led && !pl) begin
                if (ph == 2)
                    per = n;
                n = 0;
                ph++;
            end
            if (ph == 2 && smp) begin
                sp = n;
                ns++;
            end
            if (ph == 2 && pl && !led)
                hi = n;
            pl = led;
        end
        `CHK(per, 2 * dd)
        `CHK(hi, dd)
        `CHK(sp, lag_of(cd))
        `CHK(ns, 1)
        rd(ADDR_LED_PULSE_DIVIDER, dv);
        rd(ADDR_RECEIVER_SAMPLE_LAG, cd);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    // about eight times the expected run
    initial begin
        #800_000;
        err_count++;
        results();
    end

    initial begin
        i_reset_n = 1'b0;
        req = '0;
        cv = '{default: '0};
        res = '{default: '0};
        err_count = 0;
        checks = 0;
        void'($urandom(32'h9315));
        repeat (10) @(posedge i_mclk);
        #2 i_reset_n = 1'b1;
        `CHK(pdf, 1'b1)
        `CHK(pdu, 1'b1)
        rd(ADDR_LED_PULSE_DIVIDER, RST_LED_PULSE_DIVIDER);
        rd(ADDR_RECEIVER_SAMPLE_LAG, RST_RECEIVER_SAMPLE_LAG);
        for (int a = 8'h41; a <= 8'h46; a++)
            rd(a[7:0], 8'h00);
        meas(RST_LED_PULSE_DIVIDER, RST_RECEIVER_SAMPLE_LAG);
        for (int i = 0; i < 6; i++)
            meas(d_tab[i], c_tab[i]);
        repeat (4) begin
            d = 8'(4 + $urandom_range(16));
            c = 8'($urandom_range(d));
            meas(d, c);
        end
        v = 16'($urandom);
        cnv(0, v);
        rd(ADDR_PROX_MSB, {4'h0, v[11:8]});
        w = 16'($urandom);
        cnv(0, w);
        rd(ADDR_PROX_LSB, v[7:0]);
        rd(ADDR_PROX_LSB, w[7:0]);
        wr(ADDR_PROX_MSB, 8'hff);
        rd(ADDR_PROX_MSB, {4'h0, w[11:8]});
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_LIGHT_ENABLE, m[7:0]);
            `CHK(pdf, !m[0])
            `CHK(pdu, !m[1])
            for (int j = 1; j < 3; j++) begin
                v = 16'($urandom);
                cnv(j, v);
                if (m[j - 1])
                    res[j] = v;
            end
            rd(ADDR_FILT_MSB, res[1][15:8]);
            rd(ADDR_FILT_LSB, res[1][7:0]);
            rd(ADDR_UNFILT_MSB, res[2][15:8]);
            rd(ADDR_UNFILT_LSB, res[2][7:0]);
        end
        // mid-run reset: written settings must fall back to defaults
        // lag first so it never exceeds the divider
        wr(ADDR_RECEIVER_SAMPLE_LAG, 8'h03);
        wr(ADDR_LED_PULSE_DIVIDER, 8'h08);
        wr(ADDR_LIGHT_ENABLE, 8'h03);
        @(posedge i_mclk);
        #2 i_reset_n = 1'b0;
        repeat (2) @(posedge i_mclk);
        #2 i_reset_n = 1'b1;
        `CHK(pdf, 1'b1)
        `CHK(pdu, 1'b1)
        rd(ADDR_LED_PULSE_DIVIDER, RST_LED_PULSE_DIVIDER);
        rd(ADDR_RECEIVER_SAMPLE_LAG, RST_RECEIVER_SAMPLE_LAG);
        rd(ADDR_PROX_MSB, 8'h00);
        rd(ADDR_PROX_LSB, 8'h00);
        results();
    end
endmodule

// [inc/plt_pkg.sv]
package plt_pkg;

    // ------------------------------------------------------------
    // clocking and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int REF_HZ = 4_000_000;
    // one sample lag step is one reference half period
    localparam int LAG_STEP_NS = 125;
    localparam int REF_HALF_NS = 1_000_000_000 / (2 * REF_HZ);

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LED_PULSE_DIVIDER = 8'h0d;
    localparam logic [7:0] ADDR_RECEIVER_SAMPLE_LAG = 8'h0e;
    localparam logic [7:0] ADDR_LIGHT_ENABLE = 8'h27;
    localparam logic [7:0] ADDR_PROX_MSB = 8'h41;
    localparam logic [7:0] ADDR_PROX_LSB = 8'h42;
    localparam logic [7:0] ADDR_FILT_MSB = 8'h43;
    localparam logic [7:0] ADDR_FILT_LSB = 8'h44;
    localparam logic [7:0] ADDR_UNFILT_MSB = 8'h45;
    localparam logic [7:0] ADDR_UNFILT_LSB = 8'h46;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LED_PULSE_DIVIDER = 8'h10;
    localparam logic [7:0] RST_RECEIVER_SAMPLE_LAG = 8'h05;
    localparam logic [1:0] RST_LIGHT_ENABLE = 2'h0;
    localparam int LIGHT_EN_FILT_BIT = 0;
    localparam int LIGHT_EN_UNFILT_BIT = 1;
    localparam int LAG_CODE_W = 5;
    localparam int PROX_W = 12;
    localparam int LIGHT_W = 16;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } plt_reg_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] value;
    } plt_conv_t;

endpackage

// [verilog/plt_core.sv]
// Overview of operation
// - led pulse rate is the 4 MHz reference divided by led_pulse_divider
// - led_pulse_divider resets to sixteen, giving 250 KHz
// - lag codes 0 and 1 no delay; 2..31 delay (code-1)*125 ns
// - receiver_sample_lag resets to five, a 500 ns delay
// - proximity result is a 12-bit unsigned value
// - finished proximity conversion is stored in the proximity result
// - each light channel gives a 16-bit unsigned count
// - filtered and unfiltered counts sit in separate readable results
// - filtered and unfiltered channels enable independently
// - a disabled light channel is held powered down
// - proximity result msb at 0x41, lsb at 0x42, read-only
module plt_core (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // reference half-period strobe, 8 MHz rate
    input wire logic i_ref_half_tick,
    // register port from the serial engine
    input wire plt_pkg::plt_reg_req_t i_reg,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // converter results
    input wire plt_pkg::plt_conv_t i_prox_conv,
    input wire plt_pkg::plt_conv_t i_filt_conv,
    input wire plt_pkg::plt_conv_t i_unfilt_conv,
    // led and receiver timing
    output logic o_led_drive,
    output logic o_rx_sample,
    // light channel power control
    output logic o_filt_power_down,
    output logic o_unfilt_power_down
);
    import plt_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] div_r, div_nxt;
    logic [7:0] lag_r, lag_nxt;
    logic [1:0] light_en_r, light_en_nxt;
    logic [PROX_W-1:0] prox_r, prox_nxt;
    logic [LIGHT_W-1:0] filt_r, filt_nxt;
    logic [LIGHT_W-1:0] unfilt_r, unfilt_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    // low byte frozen when the matching high byte is read
    logic [7:0] prox_lo_hold_r, prox_lo_hold_nxt;
    logic [7:0] filt_lo_hold_r, filt_lo_hold_nxt;
    logic [7:0] unfilt_lo_hold_r, unfilt_lo_hold_nxt;
    logic [2:0] hold_vld_r, hold_vld_nxt;

    logic filt_en;
    logic unfilt_en;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic wr_hit(input plt_reg_req_t req,
                                    input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    function automatic logic rd_hit(input plt_reg_req_t req,
                                    input logic [7:0] addr);
        return req.rd && (req.addr == addr);
    endfunction

    assign filt_en = light_en_r[LIGHT_EN_FILT_BIT];
    assign unfilt_en = light_en_r[LIGHT_EN_UNFILT_BIT];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_comb begin
        div_nxt = div_r;
        lag_nxt = lag_r;
        light_en_nxt = light_en_r;
        // settings are taken as written; out-of-range values are
        // the host's to avoid, not refused here
        // no range check
        if (wr_hit(i_reg, ADDR_LED_PULSE_DIVIDER)) begin
            div_nxt = i_reg.wdata;
        end
        if (wr_hit(i_reg, ADDR_RECEIVER_SAMPLE_LAG)) begin
            lag_nxt = i_reg.wdata;
        end
        if (wr_hit(i_reg, ADDR_LIGHT_ENABLE)) begin
            light_en_nxt = i_reg.wdata[1:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_r <= RST_LED_PULSE_DIVIDER;
            lag_r <= RST_RECEIVER_SAMPLE_LAG;
            light_en_r <= RST_LIGHT_ENABLE;
        end else begin
            div_r <= div_nxt;
            lag_r <= lag_nxt;
            light_en_r <= light_en_nxt;
        end
    end

    // ------------------------------------------------------------
    // result capture
    // ------------------------------------------------------------
    always_comb begin
        prox_nxt = prox_r;
        filt_nxt = filt_r;
        unfilt_nxt = unfilt_r;
        if (i_prox_conv.done) begin
            prox_nxt = i_prox_conv.value[PROX_W-1:0];
        end
        // sixteen bit counts
        // a powered-down channel keeps its last count
        if (i_filt_conv.done && filt_en) begin
            filt_nxt = i_filt_conv.value;
        end
        if (i_unfilt_conv.done && unfilt_en) begin
            unfilt_nxt = i_unfilt_conv.value;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prox_r <= '0;
            filt_r <= '0;
            unfilt_r <= '0;
        end else begin
            prox_r <= prox_nxt;
            filt_r <= filt_nxt;
            unfilt_r <= unfilt_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reading a high byte freezes its low byte, so a result that
    // updates between the two reads cannot tear the pair
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        prox_lo_hold_nxt = prox_lo_hold_r;
        filt_lo_hold_nxt = filt_lo_hold_r;
        unfilt_lo_hold_nxt = unfilt_lo_hold_r;
        hold_vld_nxt = hold_vld_r;
        if (i_reg.rd) begin
            rvalid_nxt = 1'b1;
            case (i_reg.addr)
                ADDR_LED_PULSE_DIVIDER: begin
                    rdata_nxt = div_r;
                end
                ADDR_RECEIVER_SAMPLE_LAG: begin
                    rdata_nxt = lag_r;
                end
                ADDR_LIGHT_ENABLE: begin
                    rdata_nxt = {6'h00, light_en_r};
                end
                ADDR_PROX_MSB: begin
                    rdata_nxt = {4'h0, prox_r[11:8]};
                    prox_lo_hold_nxt = prox_r[7:0];
                    hold_vld_nxt[0] = 1'b1;
                end
                ADDR_PROX_LSB: begin
                    rdata_nxt = hold_vld_r[0] ? prox_lo_hold_r
                                              : prox_r[7:0];
                    hold_vld_nxt[0] = 1'b0;
                end
                ADDR_FILT_MSB: begin
                    rdata_nxt = filt_r[15:8];
                    filt_lo_hold_nxt = filt_r[7:0];
                    hold_vld_nxt[1] = 1'b1;
                end
                ADDR_FILT_LSB: begin
                    rdata_nxt = hold_vld_r[1] ? filt_lo_hold_r
                                              : filt_r[7:0];
                    hold_vld_nxt[1] = 1'b0;
                end
                ADDR_UNFILT_MSB: begin
                    rdata_nxt = unfilt_r[15:8];
                    unfilt_lo_hold_nxt = unfilt_r[7:0];
                    hold_vld_nxt[2] = 1'b1;
                end
                ADDR_UNFILT_LSB: begin
                    rdata_nxt = hold_vld_r[2] ? unfilt_lo_hold_r
                                              : unfilt_r[7:0];
                    hold_vld_nxt[2] = 1'b0;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            prox_lo_hold_r <= 8'h00;
            filt_lo_hold_r <= 8'h00;
            unfilt_lo_hold_r <= 8'h00;
            hold_vld_r <= 3'h0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            prox_lo_hold_r <= prox_lo_hold_nxt;
            filt_lo_hold_r <= filt_lo_hold_nxt;
            unfilt_lo_hold_r <= unfilt_lo_hold_nxt;
            hold_vld_r <= hold_vld_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;

    // ------------------------------------------------------------
    // led and receiver timing
    // ------------------------------------------------------------
    // led pulse and sample strobe generator
    plt_pulse_gen u_pulse (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_half_tick(i_ref_half_tick),
        .i_divider(div_r),
        .i_lag_code(lag_r),
        .o_led(o_led_drive),
        .o_sample(o_rx_sample)
    );

    // ------------------------------------------------------------
    // light channel power
    // ------------------------------------------------------------
    // disabled channel powered down
    assign o_filt_power_down = ~filt_en;
    assign o_unfilt_power_down = ~unfilt_en;
endmodule

// [verilog/plt_pulse_gen.sv]
module plt_pulse_gen (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // reference half-period strobe
    input wire logic i_half_tick,
    // settings
    input wire logic [7:0] i_divider,
    input wire logic [7:0] i_lag_code,
    // outputs
    output logic o_led,
    output logic o_sample
);
    import plt_pkg::*;

    // ------------------------------------------------------------
    // period counter in half-period steps
    // ------------------------------------------------------------
    logic [8:0] cnt_r, cnt_nxt;
    logic led_r, led_nxt;
    logic smp_r, smp_nxt;
    logic [7:0] div_eff;
    logic [8:0] period;
    logic [8:0] lag_eff;

    always_comb begin
        // divider of zero would stall the led; run it as one
        div_eff = (i_divider == 8'h00) ? 8'h01 : i_divider;
        period = {div_eff, 1'b0};
        if (i_lag_code[LAG_CODE_W-1:0] <= 5'h01) begin
            lag_eff = 9'h000;
        end else begin
            lag_eff = {4'h0, i_lag_code[LAG_CODE_W-1:0] - 5'h01};
        end
        cnt_nxt = cnt_r;
        led_nxt = led_r;
        smp_nxt = 1'b0;
        if (i_half_tick) begin
            if (cnt_r >= period - 9'h001) begin
                cnt_nxt = 9'h000;
            end else begin
                cnt_nxt = cnt_r + 9'h001;
            end
            led_nxt = (cnt_nxt < {1'b0, div_eff});
            smp_nxt = (cnt_nxt == lag_eff);
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r <= 9'h1ff;
            led_r <= 1'b0;
            smp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            led_r <= led_nxt;
            smp_r <= smp_nxt;
        end
    end

    assign o_led = led_r;
    assign o_sample = smp_r;
endmodule
